// >>> hw/aux_ctrl.sv
`timescale 1ns/1ps
// Contract
// R1: select 0 gives 3.3V, 1 gives 1.8V; ignored sharing
// R2: stand-alone enable in Normal locks stand-alone
// R3: share enable chooses sharing; stand-alone bit void
// R4: chosen configuration fixed while powered
// R5: stand-alone locked: on/off ok, changes ignored silently
// R6: sharing locked: change attempts set access fault
// R7: on/off state per mode and configuration
// R8: stop disables sharing unless share-in-stop set
// R9: stop adds high-power path with hysteresis
// R10: normal mode uses high-power path only
// R11: battery undervoltage switches off unless keep-on
// R12: overcurrent limits, flags; clear only after gone
// R13: stand-alone undervoltage sets undervoltage flag
// R14: sharing: no undervoltage, no overcurrent signalling
// R15: host configures right after power-up
// R16: host matches sharing voltage to main regulator
// R17: lock cleared only by power-on reset
module aux_ctrl (
  input wire logic mclk, // 25 MHz system clock
  input wire logic rst_n, // power-on reset, synchronous, active low
  input wire logic soft_rst_n, // device soft reset, same clock, active low
  input wire logic [2:0] dev_mode, // device operating mode, same clock
  input wire logic bat_uv_in, // battery below threshold, asynchronous
  input wire logic shunt_oc_in, // shunt threshold reached, asynchronous
  input wire logic out_uv_in, // regulator output undervoltage, asynchronous
  input wire logic base_hi_in, // base current above rising threshold
  input wire logic base_lo_in, // base current below falling threshold
  input wire logic [4:0] s_axi_awaddr, // write address
  input wire logic s_axi_awvalid, // write address valid
  output logic s_axi_awready, // write address ready
  input wire logic [31:0] s_axi_wdata, // write data
  input wire logic [3:0] s_axi_wstrb, // write strobes
  input wire logic s_axi_wvalid, // write data valid
  output logic s_axi_wready, // write data ready
  output logic [1:0] s_axi_bresp, // write response
  output logic s_axi_bvalid, // write response valid
  input wire logic s_axi_bready, // write response ready
  input wire logic [4:0] s_axi_araddr, // read address
  input wire logic s_axi_arvalid, // read address valid
  output logic s_axi_arready, // read address ready
  output logic [31:0] s_axi_rdata, // read data
  output logic [1:0] s_axi_rresp, // read response
  output logic s_axi_rvalid, // read data valid
  input wire logic s_axi_rready, // read data ready
  output logic aux_reg_on, // regulator enabled
  output logic aux_vsel_1v8, // 1 selects 1.8 V, 0 selects 3.3 V
  output logic aux_hp_en, // high-power regulator path
  output logic aux_lp_en, // low-power regulator path
  output logic aux_share_on, // load sharing active
  output logic aux_limit_en, // shunt current limit armed
  output logic aux_uv_mon_en, // output undervoltage monitor armed
  output logic irq // level interrupt, high while unmasked flag set
);
  // synchronised analog inputs
  logic bat_uv; // battery undervoltage
  logic shunt_oc; // overcurrent present
  logic out_uv; // output undervoltage
  logic base_hi; // above rising threshold
  logic base_lo; // below falling threshold
  aux_pkg::aux_cfg_t cfg_r; // chosen configuration, power-on reset only
  logic sa_en_r; // aux_standalone_enable
  logic [3:0] hardware_control_reg_r; // hardware_control_reg bits
  logic [aux_pkg::NFLAG-1:0] flag_r; // sticky flags
  logic [aux_pkg::NFLAG-1:0] mask_r; // interrupt mask
  logic hp_r; // high-power hysteresis state outside normal mode
  // axi write side
  logic aw_hold_r; // address held
  logic w_hold_r; // data held
  logic [4:0] awaddr_r; // held address
  logic [31:0] wdata_r; // held data
  logic wstrb0_r; // low byte strobe
  logic wr_go; // both halves present, commit
  logic wr_hit; // mapped write address
  logic wr_mode; // write to mode control
  logic wr_hw; // write to hardware control
  logic wr_stat; // write to flag register
  logic wr_mask; // write to mask register
  logic [31:0] rd_val; // read mux value
  logic rd_hit; // mapped read address
  logic ev_fault; // access fault event
  logic [aux_pkg::NFLAG-1:0] ev; // flag set events
  logic [aux_pkg::NFLAG-1:0] clr; // flag clear requests
  logic on_nxt; // regulator on, next
  aux_pkg::aux_mode_t mode; // typed mode

  assign mode = aux_pkg::aux_mode_t'(dev_mode);

  // pin inputs cross into the clock domain
  aux_sync3 #(
    .W(5)
  ) u_sync (
    .mclk(mclk),
    .rst_n(rst_n),
    .din({bat_uv_in, shunt_oc_in, out_uv_in, base_hi_in, base_lo_in}),
    .dout({bat_uv, shunt_oc, out_uv, base_hi, base_lo})
  );

  // write channels taken independently
  assign s_axi_awready = !aw_hold_r && !s_axi_bvalid;
  assign s_axi_wready = !w_hold_r && !s_axi_bvalid;
  assign wr_go = aw_hold_r && w_hold_r && !s_axi_bvalid;
  assign wr_mode = wr_go && wstrb0_r && (awaddr_r == aux_pkg::OFS_MODE_CTRL);
  assign wr_hw = wr_go && wstrb0_r && (awaddr_r == aux_pkg::OFS_HARDWARE_CONTROL_REG);
  assign wr_stat = wr_go && wstrb0_r && (awaddr_r == aux_pkg::OFS_IRQ_STAT);
  assign wr_mask = wr_go && wstrb0_r && (awaddr_r == aux_pkg::OFS_IRQ_MASK);
  assign wr_hit = (awaddr_r == aux_pkg::OFS_MODE_CTRL) || (awaddr_r == aux_pkg::OFS_HARDWARE_CONTROL_REG)
    || (awaddr_r == aux_pkg::OFS_STATE) || (awaddr_r == aux_pkg::OFS_IRQ_STAT)
    || (awaddr_r == aux_pkg::OFS_IRQ_MASK);

  // capture address and data halves
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      aw_hold_r <= 1'b0;
      w_hold_r <= 1'b0;
      awaddr_r <= 5'h00;
      wdata_r <= 32'h0000_0000;
      wstrb0_r <= 1'b0;
    end
    else
    begin
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold_r <= 1'b1;
        awaddr_r <= {s_axi_awaddr[4:2], 2'b00};
      end
      else if (wr_go)
        aw_hold_r <= 1'b0;
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold_r <= 1'b1;
        wdata_r <= s_axi_wdata;
        wstrb0_r <= s_axi_wstrb[0];
      end
      else if (wr_go)
        w_hold_r <= 1'b0;
    end
  end

  // write response, one cycle after both halves are held
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= aux_pkg::RESP_OKAY;
    end
    else if (wr_go)
    begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= wr_hit ? aux_pkg::RESP_OKAY : aux_pkg::RESP_SLVERR;
    end
    else if (s_axi_bready)
      s_axi_bvalid <= 1'b0;
  end

  // configuration lock, survives soft reset
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      cfg_r <= aux_pkg::AUX_CFG_NONE; // R17
    else if (cfg_r == aux_pkg::AUX_CFG_NONE)
    begin
      if (wr_hw && wdata_r[aux_pkg::B_SHARE])
        cfg_r <= aux_pkg::AUX_CFG_SHARE; // R3 R4
      else if (wr_mode && wdata_r[aux_pkg::B_SA_EN] && !hardware_control_reg_r[aux_pkg::B_SHARE]
               && mode == aux_pkg::AUX_M_NORMAL)
        cfg_r <= aux_pkg::AUX_CFG_ALONE; // R2 R4
    end
  end

  // attempts to leave a locked sharing setup are faults
  always_comb
  begin
    ev_fault = 1'b0;
    if (cfg_r == aux_pkg::AUX_CFG_SHARE)
    begin
      if (wr_hw && !wdata_r[aux_pkg::B_SHARE])
        ev_fault = 1'b1; // R6
      if (wr_mode && wdata_r[aux_pkg::B_SA_EN])
        ev_fault = 1'b1; // R6
    end
  end

  // stand-alone on/off, written only in normal mode
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !soft_rst_n)
      sa_en_r <= 1'b0;
    else if (wr_mode && mode == aux_pkg::AUX_M_NORMAL
             && cfg_r != aux_pkg::AUX_CFG_SHARE && !hardware_control_reg_r[aux_pkg::B_SHARE])
      sa_en_r <= wdata_r[aux_pkg::B_SA_EN]; // R3 R5
  end

  // hardware control; share bit sticks once sharing is locked
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      hardware_control_reg_r <= aux_pkg::RST_HARDWARE_CONTROL_REG;
    else if (!soft_rst_n)
    begin
      hardware_control_reg_r <= aux_pkg::RST_HARDWARE_CONTROL_REG;
      hardware_control_reg_r[aux_pkg::B_SHARE] <= (cfg_r == aux_pkg::AUX_CFG_SHARE); // R4
    end
    else if (wr_hw)
    begin
      hardware_control_reg_r[aux_pkg::B_SHARE_STOP] <= wdata_r[aux_pkg::B_SHARE_STOP];
      hardware_control_reg_r[aux_pkg::B_KEEP_ON] <= wdata_r[aux_pkg::B_KEEP_ON];
      hardware_control_reg_r[aux_pkg::B_VSEL] <= wdata_r[aux_pkg::B_VSEL];
      if (cfg_r == aux_pkg::AUX_CFG_NONE)
        hardware_control_reg_r[aux_pkg::B_SHARE] <= wdata_r[aux_pkg::B_SHARE]; // R3
      // locked stand-alone: share write dropped without fault R5
    end
  end

  // regulator on/off by mode and configuration
  always_comb
  begin
    on_nxt = 1'b0;
    unique case (cfg_r)
      aux_pkg::AUX_CFG_ALONE:
      begin
        unique case (mode)
          aux_pkg::AUX_M_NORMAL,
          aux_pkg::AUX_M_STOP,
          aux_pkg::AUX_M_SLEEP,
          aux_pkg::AUX_M_RESTART: on_nxt = sa_en_r; // R7 fixed outside normal
          default: on_nxt = 1'b0; // R7 init, fail-safe
        endcase
      end
      aux_pkg::AUX_CFG_SHARE:
      begin
        unique case (mode)
          aux_pkg::AUX_M_NORMAL: on_nxt = 1'b1; // R7
          aux_pkg::AUX_M_STOP: on_nxt = hardware_control_reg_r[aux_pkg::B_SHARE_STOP]; // R8
          aux_pkg::AUX_M_RESTART: on_nxt = 1'b1; // R7
          default: on_nxt = 1'b0; // R7 R14 sleep, init, fail-safe
        endcase
      end
      default: on_nxt = 1'b0; // not yet configured
    endcase
    if (bat_uv && !hardware_control_reg_r[aux_pkg::B_KEEP_ON])
      on_nxt = 1'b0; // R11
  end

  // high-power hysteresis on base current outside normal mode
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      hp_r <= 1'b0;
    else if (mode == aux_pkg::AUX_M_NORMAL)
      hp_r <= 1'b0;
    else if (base_hi)
      hp_r <= 1'b1; // R9
    else if (base_lo)
      hp_r <= 1'b0; // R9
  end

  // regulator drive outputs
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      aux_reg_on <= 1'b0;
      aux_vsel_1v8 <= 1'b0;
      aux_hp_en <= 1'b0;
      aux_lp_en <= 1'b0;
      aux_share_on <= 1'b0;
      aux_limit_en <= 1'b0;
      aux_uv_mon_en <= 1'b0;
    end
    else
    begin
      aux_reg_on <= on_nxt;
      aux_vsel_1v8 <= (cfg_r == aux_pkg::AUX_CFG_ALONE) && hardware_control_reg_r[aux_pkg::B_VSEL]; // R1
      aux_hp_en <= on_nxt && (mode == aux_pkg::AUX_M_NORMAL || hp_r); // R9 R10
      aux_lp_en <= on_nxt && mode != aux_pkg::AUX_M_NORMAL; // R10
      aux_share_on <= on_nxt && cfg_r == aux_pkg::AUX_CFG_SHARE; // R8
      aux_limit_en <= on_nxt && cfg_r == aux_pkg::AUX_CFG_ALONE; // R12 R14
      aux_uv_mon_en <= on_nxt && cfg_r == aux_pkg::AUX_CFG_ALONE; // R13 R14
    end
  end

  // flag set events and clear requests
  always_comb
  begin
    ev = '0;
    ev[aux_pkg::B_F_OC] = aux_limit_en && shunt_oc; // R12 R14
    ev[aux_pkg::B_F_UV] = aux_uv_mon_en && out_uv; // R13 R14
    ev[aux_pkg::B_F_FAULT] = ev_fault; // R6
    clr = wr_stat ? wdata_r[aux_pkg::NFLAG-1:0] : '0;
    if (shunt_oc)
      clr[aux_pkg::B_F_OC] = 1'b0; // R12
  end

  // sticky flags, set wins over clear
  always_ff @(posedge mclk)
  begin
    if (!rst_n || !soft_rst_n)
      flag_r <= aux_pkg::RST_FLAGS;
    else
      flag_r <= (flag_r & ~clr) | ev;
  end

  // interrupt mask
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
      mask_r <= '0;
    else if (wr_mask)
      mask_r <= wdata_r[aux_pkg::NFLAG-1:0];
  end

  assign irq = |(flag_r & mask_r);

  // read decode
  always_comb
  begin
    rd_val = 32'h0000_0000;
    rd_hit = 1'b1;
    unique case ({s_axi_araddr[4:2], 2'b00})
      aux_pkg::OFS_MODE_CTRL: rd_val[aux_pkg::B_SA_EN] = sa_en_r;
      aux_pkg::OFS_HARDWARE_CONTROL_REG: rd_val[3:0] = hardware_control_reg_r;
      aux_pkg::OFS_STATE:
      begin
        rd_val[aux_pkg::B_ST_CFG +: 2] = cfg_r;
        rd_val[aux_pkg::B_ST_ON] = aux_reg_on;
        rd_val[aux_pkg::B_ST_HP] = aux_hp_en;
        rd_val[aux_pkg::B_ST_LP] = aux_lp_en;
        rd_val[aux_pkg::B_ST_BATUV] = bat_uv;
        rd_val[aux_pkg::B_ST_OC] = shunt_oc;
      end
      aux_pkg::OFS_IRQ_STAT: rd_val[aux_pkg::NFLAG-1:0] = flag_r;
      aux_pkg::OFS_IRQ_MASK: rd_val[aux_pkg::NFLAG-1:0] = mask_r;
      default: rd_hit = 1'b0; // unmapped
    endcase
  end

  assign s_axi_arready = !s_axi_rvalid;

  // read data channel, answer one cycle after address
  always_ff @(posedge mclk)
  begin
    if (!rst_n)
    begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= 32'h0000_0000;
      s_axi_rresp <= aux_pkg::RESP_OKAY;
    end
    else if (s_axi_arvalid && s_axi_arready)
    begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata <= rd_val;
      s_axi_rresp <= rd_hit ? aux_pkg::RESP_OKAY : aux_pkg::RESP_SLVERR;
    end
    else if (s_axi_rready)
      s_axi_rvalid <= 1'b0;
  end
endmodule : aux_ctrl

// >>> hw/aux_pkg.sv
package aux_pkg;
  // register byte offsets
  localparam logic [4:0] OFS_MODE_CTRL = 5'h00; // stand-alone on/off
  localparam logic [4:0] OFS_HARDWARE_CONTROL_REG = 5'h04; // hardware_control_reg
  localparam logic [4:0] OFS_STATE = 5'h08; // live state, read only
  localparam logic [4:0] OFS_IRQ_STAT = 5'h0C; // sticky flags, write one to clear
  localparam logic [4:0] OFS_IRQ_MASK = 5'h10; // interrupt mask
  // mode control fields
  localparam int B_SA_EN = 0; // aux_standalone_enable
  // hardware control fields
  localparam int B_SHARE = 0; // aux_share_enable
  localparam int B_SHARE_STOP = 1; // share_in_stop_enable
  localparam int B_KEEP_ON = 2; // aux_keep_on_low_battery
  localparam int B_VSEL = 3; // aux_voltage_select, 1 = 1.8 V
  // state register fields
  localparam int B_ST_CFG = 0; // two bits, chosen configuration
  localparam int B_ST_ON = 2; // regulator on
  localparam int B_ST_HP = 3; // high-power path
  localparam int B_ST_LP = 4; // low-power path
  localparam int B_ST_BATUV = 5; // battery below threshold
  localparam int B_ST_OC = 6; // overcurrent present now
  // flag fields
  localparam int B_F_OC = 0; // aux_overcurrent_flag
  localparam int B_F_UV = 1; // aux_undervoltage_flag
  localparam int B_F_FAULT = 2; // serial access fault
  localparam int NFLAG = 3; // number of flags
  // reset values
  localparam logic [3:0] RST_HARDWARE_CONTROL_REG = 4'h0; // all control bits clear
  localparam logic [NFLAG-1:0] RST_FLAGS = 3'h0; // no flags
  // axi responses
  localparam logic [1:0] RESP_OKAY = 2'h0; // okay
  localparam logic [1:0] RESP_SLVERR = 2'h2; // unmapped address
  // chosen configuration
  typedef enum logic [1:0] {
    AUX_CFG_NONE = 2'b00,
    AUX_CFG_ALONE = 2'b01,
    AUX_CFG_SHARE = 2'b10
  } aux_cfg_t;
  // device operating mode
  typedef enum logic [2:0] {
    AUX_M_INIT = 3'b000,
    AUX_M_NORMAL = 3'b001,
    AUX_M_STOP = 3'b010,
    AUX_M_SLEEP = 3'b011,
    AUX_M_RESTART = 3'b100,
    AUX_M_FAILSAFE = 3'b101
  } aux_mode_t;
endpackage : aux_pkg

// >>> hw/aux_sync3.sv
`timescale 1ns/1ps
// three-stage input synchroniser; output moves once stages two and three agree
module aux_sync3 #(
  parameter int W = 1
) (
  input wire logic mclk, // system clock
  input wire logic rst_n, // synchronous reset, active low
  input wire logic [W-1:0] din, // asynchronous inputs
  output logic [W-1:0] dout // filtered, synchronous outputs
);
  genvar i;
  generate
    for (i = 0; i < W; i++)
    begin : g_bit
      logic s1_r; // first stage, read only by s2
      logic s2_r; // second stage
      logic s3_r; // third stage
      // shift chain
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
        begin
          s1_r <= 1'b0;
          s2_r <= 1'b0;
          s3_r <= 1'b0;
        end
        else
        begin
          s1_r <= din[i];
          s2_r <= s1_r;
          s3_r <= s2_r;
        end
      end
      // accept a change only when the last two stages agree
      always_ff @(posedge mclk)
      begin
        if (!rst_n)
          dout[i] <= 1'b0;
        else if (s2_r == s3_r)
          dout[i] <= s3_r;
      end
    end
  endgenerate
endmodule : aux_sync3

// >>> verif/aux_ctrl_props.sv
`timescale 1ns/1ps
// output relations against mode and configuration
module aux_ctrl_props (
  input wire logic mclk, // clock
  input wire logic rst_n, // power-on reset
  input wire logic [2:0] dev_mode, // device mode
  input wire logic aux_reg_on, // regulator on
  input wire logic aux_vsel_1v8, // 1.8 v select
  input wire logic aux_hp_en, // high-power path
  input wire logic aux_lp_en, // low-power path
  input wire logic aux_share_on, // sharing active
  input wire logic aux_limit_en, // limit armed
  input wire logic aux_uv_mon_en, // monitor armed
  input wire logic irq // interrupt
);
  default clocking @(posedge mclk); endclocking
  default disable iff (!rst_n);
  // mode seen on two edges, so registered outputs have followed it
  sequence in_mode(logic [2:0] m);
    (dev_mode == m) [*2];
  endsequence
  vsel_share_a:
    assert property (aux_share_on |-> !aux_vsel_1v8) else $error("select acts in sharing");
  share_quiet_a:
    assert property (aux_share_on |-> !aux_limit_en && !aux_uv_mon_en)
    else $error("monitors armed in sharing");
  limit_on_a:
    assert property (aux_limit_en |-> aux_reg_on && aux_uv_mon_en) else $error("limit armed off");
  alone_armed_a:
    assert property (aux_reg_on && !aux_share_on |-> aux_limit_en && aux_uv_mon_en)
    else $error("stand-alone monitors not armed");
  normal_hp_a:
    assert property (in_mode(aux_pkg::AUX_M_NORMAL) ##0 aux_reg_on |-> aux_hp_en && !aux_lp_en)
    else $error("normal path wrong");
  stop_lp_a:
    assert property (in_mode(aux_pkg::AUX_M_STOP) ##0 aux_reg_on |-> aux_lp_en)
    else $error("stop low-power path off");
  init_off_a:
    assert property (in_mode(aux_pkg::AUX_M_INIT) |-> !aux_reg_on && !aux_share_on)
    else $error("on in init");
  failsafe_off_a:
    assert property (in_mode(aux_pkg::AUX_M_FAILSAFE) |-> !aux_reg_on && !aux_share_on)
    else $error("on in fail-safe");
  share_rise_a:
    assert property ($rose(aux_share_on) |-> !($past(dev_mode) inside
      {aux_pkg::AUX_M_INIT, aux_pkg::AUX_M_SLEEP, aux_pkg::AUX_M_FAILSAFE}))
    else $error("sharing started in off mode");
  // main scenarios reached
  cover property (aux_share_on ##1 !aux_share_on);
  cover property (aux_limit_en && irq);
  cover property (in_mode(aux_pkg::AUX_M_STOP) ##0 aux_hp_en);
endmodule : aux_ctrl_props
bind aux_ctrl aux_ctrl_props i_props (.mclk, .rst_n, .dev_mode, .aux_reg_on, .aux_vsel_1v8,
  .aux_hp_en, .aux_lp_en, .aux_share_on, .aux_limit_en, .aux_uv_mon_en, .irq);

// >>> verif/aux_host.sv
`timescale 1ns/1ps
// host model: axi4-lite master, one transfer at a time, bounded waits
module aux_host (
  input wire logic mclk, // clock
  output logic [4:0] s_axi_awaddr = 5'h00, // write addr
  output logic s_axi_awvalid = 1'h0, // addr valid
  input wire logic s_axi_awready, // addr ready
  output logic [31:0] s_axi_wdata = 32'h0000_0000, // data
  output logic [3:0] s_axi_wstrb = 4'h0, // strobes
  output logic s_axi_wvalid = 1'h0, // data valid
  input wire logic s_axi_wready, // data ready
  input wire logic [1:0] s_axi_bresp, // response
  input wire logic s_axi_bvalid, // resp valid
  output logic s_axi_bready = 1'h0, // resp ready
  output logic [4:0] s_axi_araddr = 5'h00, // read addr
  output logic s_axi_arvalid = 1'h0, // addr valid
  input wire logic s_axi_arready, // addr ready
  input wire logic [31:0] s_axi_rdata, // read data
  input wire logic [1:0] s_axi_rresp, // response
  input wire logic s_axi_rvalid, // data valid
  output logic s_axi_rready = 1'h0 // data ready
);
  int tmo = 0; // waits that ran out
  // write: both halves offered, each dropped once taken, then the response
  task automatic wr(input logic [4:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_wstrb <= 4'hf;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      s_axi_awvalid <= s_axi_awvalid && !s_axi_awready;
      s_axi_wvalid <= s_axi_wvalid && !s_axi_wready;
      if (s_axi_bvalid) break;
    end
    r = s_axi_bresp;
    s_axi_bready <= 1'h0;
    tmo += int'(n == 40);
    @(posedge mclk);
  endtask : wr
  // read: address held until taken, data taken with rvalid
  task automatic rd(input logic [4:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    for (n = 0; n < 40; n++)
    begin
      @(posedge mclk);
      s_axi_arvalid <= s_axi_arvalid && !s_axi_arready;
      if (s_axi_rvalid) break;
    end
    d = s_axi_rdata;
    r = s_axi_rresp;
    s_axi_rready <= 1'h0;
    tmo += int'(n == 40);
    @(posedge mclk);
  endtask : rd
endmodule : aux_host

// >>> verif/tb_ext_regulator_config_control.sv
`timescale 1ns/1ps
// bench: host traffic, mode and sensor stimulus, register and pin checks
module tb_ext_regulator_config_control;
  logic mclk = 1'h0, rst_n = 1'h0, soft_rst_n = 1'h1; // clock, resets
  logic [2:0] dev_mode = 3'h0; // device mode
  logic bat_uv_in = 1'h0, shunt_oc_in = 1'h0, out_uv_in = 1'h0; // sensors
  logic base_hi_in = 1'h0, base_lo_in = 1'h0; // base current
  logic [4:0] s_axi_awaddr, s_axi_araddr; // addresses
  logic [31:0] s_axi_wdata, s_axi_rdata; // data
  logic [3:0] s_axi_wstrb; // strobes
  logic [1:0] s_axi_bresp, s_axi_rresp; // responses
  logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready; // write
  logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready; // handshakes
  logic s_axi_rvalid, s_axi_rready; // read
  logic aux_reg_on, aux_vsel_1v8, aux_hp_en, aux_lp_en; // regulator pins
  logic aux_share_on, aux_limit_en, aux_uv_mon_en, irq; // status pins
  logic [31:0] d; // last read
  logic [1:0] r; // last response
  int bad_count = 0; // mismatches
  int num_checks = 0; // comparisons
  always #20 mclk = ~mclk; // 25 mhz
  aux_ctrl i_dut (.mclk, .rst_n, .soft_rst_n, .dev_mode, .bat_uv_in, .shunt_oc_in,
    .out_uv_in, .base_hi_in, .base_lo_in, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
    .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid,
    .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
    .s_axi_rresp, .s_axi_rvalid, .s_axi_rready, .aux_reg_on, .aux_vsel_1v8, .aux_hp_en,
    .aux_lp_en, .aux_share_on, .aux_limit_en, .aux_uv_mon_en, .irq);
  aux_host i_host (.mclk, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready, .s_axi_wdata,
    .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready,
    .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata, .s_axi_rresp,
    .s_axi_rvalid, .s_axi_rready);
  // compare and count
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic cyc(input int n);
    repeat (n) @(posedge mclk);
  endtask : cyc
  // bus wrappers end the run on a host timeout
  task automatic w(input logic [4:0] a, input logic [31:0] v);
    i_host.wr(a, v, r);
    if (i_host.tmo != 0) print_verdict();
  endtask : w
  task automatic rd(input logic [4:0] a);
    i_host.rd(a, d, r);
    if (i_host.tmo != 0) print_verdict();
  endtask : rd
  task automatic rc(input logic [4:0] a, input logic [31:0] v);
    rd(a);
    chk(d, v);
  endtask : rc
  task automatic cfg(input logic [1:0] v);
    rd(aux_pkg::OFS_STATE);
    chk(d[1:0], v);
  endtask : cfg
  task automatic md(input logic [2:0] m);
    dev_mode <= m;
    cyc(3);
  endtask : md
  task automatic sr;
    soft_rst_n <= 1'h0;
    cyc(2);
    soft_rst_n <= 1'h1;
    cyc(2);
  endtask : sr
  task automatic print_verdict;
    bad_count += i_host.tmo;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : print_verdict
  initial
  begin
    cyc(20);
    rst_n <= 1'h1;
    dev_mode <= aux_pkg::AUX_M_NORMAL;
    cyc(1);
    // stand-alone at 1.8 v, set straight after power-up
    rc(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'h0);
    w(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'h8);
    cfg(2'h0);
    w(aux_pkg::OFS_MODE_CTRL, 4'h1);
    rc(aux_pkg::OFS_STATE, 8'h0d);
    chk(aux_vsel_1v8, 1'h1);
    chk(aux_uv_mon_en, 1'h1);
    w(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'h9);
    cfg(2'h1);
    rc(aux_pkg::OFS_IRQ_STAT, 3'h0);
    w(5'h14, 4'h1);
    chk(r, aux_pkg::RESP_SLVERR);
    rc(5'h1c, 4'h0);
    chk(r, aux_pkg::RESP_SLVERR);
    // overcurrent flag sticks while present; interrupt follows mask
    w(aux_pkg::OFS_IRQ_MASK, 3'h7);
    shunt_oc_in <= 1'h1;
    cyc(8);
    chk(irq, 1'h1);
    rc(aux_pkg::OFS_STATE, 8'h4d);
    w(aux_pkg::OFS_IRQ_STAT, 3'h1);
    rc(aux_pkg::OFS_IRQ_STAT, 3'h1);
    shunt_oc_in <= 1'h0;
    cyc(8);
    w(aux_pkg::OFS_IRQ_STAT, 3'h1);
    rc(aux_pkg::OFS_IRQ_STAT, 3'h0);
    chk(irq, 1'h0);
    w(aux_pkg::OFS_IRQ_MASK, 3'h5);
    out_uv_in <= 1'h1;
    cyc(8);
    out_uv_in <= 1'h0;
    rc(aux_pkg::OFS_IRQ_STAT, 3'h2);
    chk(irq, 1'h0);
    // battery low: off, back on; keep-on holds it
    bat_uv_in <= 1'h1;
    cyc(8);
    chk(aux_reg_on, 1'h0);
    bat_uv_in <= 1'h0;
    cyc(8);
    chk(aux_reg_on, 1'h1);
    w(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'hc);
    bat_uv_in <= 1'h1;
    cyc(8);
    chk(aux_reg_on, 1'h1);
    bat_uv_in <= 1'h0;
    // stop: state held, high-power path with hysteresis
    md(aux_pkg::AUX_M_STOP);
    chk(aux_reg_on, 1'h1);
    chk(aux_lp_en, 1'h1);
    chk(aux_hp_en, 1'h0);
    base_hi_in <= 1'h1;
    cyc(8);
    base_hi_in <= 1'h0;
    cyc(8);
    chk(aux_hp_en, 1'h1);
    base_lo_in <= 1'h1;
    cyc(8);
    base_lo_in <= 1'h0;
    chk(aux_hp_en, 1'h0);
    md(aux_pkg::AUX_M_NORMAL);
    chk(aux_lp_en, 1'h0);
    w(aux_pkg::OFS_MODE_CTRL, 4'h0);
    chk(aux_reg_on, 1'h0);
    sr();
    w(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'h1);
    cfg(2'h1);
    chk(aux_vsel_1v8, 1'h0);
    rc(aux_pkg::OFS_IRQ_STAT, 3'h0);
    w(aux_pkg::OFS_MODE_CTRL, 4'h1);
    chk(aux_reg_on, 1'h1);
    md(aux_pkg::AUX_M_FAILSAFE);
    chk(aux_reg_on, 1'h0);
    md(aux_pkg::AUX_M_INIT);
    chk(aux_reg_on, 1'h0);
    $display("test stand_alone done");
    // fresh power-up, then load sharing
    rst_n <= 1'h0;
    cyc(20);
    rst_n <= 1'h1;
    dev_mode <= aux_pkg::AUX_M_NORMAL;
    cyc(1);
    w(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'h1);
    cfg(2'h2);
    chk(aux_share_on, 1'h1);
    w(aux_pkg::OFS_MODE_CTRL, 4'h1);
    rc(aux_pkg::OFS_MODE_CTRL, 4'h0);
    rc(aux_pkg::OFS_IRQ_STAT, 3'h4);
    w(aux_pkg::OFS_IRQ_STAT, 3'h4);
    rc(aux_pkg::OFS_IRQ_STAT, 3'h0);
    w(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'h0);
    rc(aux_pkg::OFS_IRQ_STAT, 3'h4);
    w(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'h9);
    chk(aux_vsel_1v8, 1'h0);
    shunt_oc_in <= 1'h1;
    out_uv_in <= 1'h1;
    cyc(8);
    chk(aux_limit_en, 1'h0);
    rc(aux_pkg::OFS_IRQ_STAT, 3'h4);
    shunt_oc_in <= 1'h0;
    out_uv_in <= 1'h0;
    bat_uv_in <= 1'h1;
    cyc(8);
    chk(aux_share_on, 1'h0);
    bat_uv_in <= 1'h0;
    cyc(8);
    chk(aux_share_on, 1'h1);
    md(aux_pkg::AUX_M_STOP);
    chk(aux_share_on, 1'h0);
    rc(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'h9);
    md(aux_pkg::AUX_M_NORMAL);
    chk(aux_share_on, 1'h1);
    w(aux_pkg::OFS_HARDWARE_CONTROL_REG, 4'h3);
    md(aux_pkg::AUX_M_STOP);
    chk(aux_share_on, 1'h1);
    md(aux_pkg::AUX_M_SLEEP);
    chk(aux_share_on, 1'h0);
    md(aux_pkg::AUX_M_RESTART);
    chk(aux_share_on, 1'h1);
    md(aux_pkg::AUX_M_FAILSAFE);
    chk(aux_share_on, 1'h0);
    sr();
    md(aux_pkg::AUX_M_NORMAL);
    cfg(2'h2);
    chk(aux_share_on, 1'h1);
    $display("test load_share done");
    print_verdict();
  end
endmodule : tb_ext_regulator_config_control
